// ---- logic/cksp_pkg.sv ----
package cksp_pkg;

	// ------------------------------------------------------------
	// bus geometry and register map
	// ------------------------------------------------------------
	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
	localparam logic [7:0] OFF_CLK_DIV = 8'h04;
	localparam logic [7:0] OFF_FB_DIV = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int OC_CUR_LSB = 12;
	localparam int OC_NEW_LSB = 8;
	localparam int OC_SWLOCK_BIT = 7;
	localparam int OC_PLLLOCK_BIT = 5;
	localparam int OC_FAIL_BIT = 3;
	localparam int OC_SECEN_BIT = 1;
	localparam int OC_SWREQ_BIT = 0;
	localparam int CD_RCDIV_LSB = 8;
	localparam int CD_POST_LSB = 6;
	localparam int CD_PRE_LSB = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [2:0] RST_SOURCE = 3'h7;
	localparam logic [1:0] RST_PRI_MODE = 2'h0;
	localparam logic [4:0] RST_PRESCALE = 5'h00;
	localparam logic [1:0] RST_POSTSCALE = 2'h0;
	localparam logic [2:0] RST_RC_DIV = 3'h0;
	localparam logic [8:0] RST_FB_DIV = 9'h030;

	// ------------------------------------------------------------
	// source codes, primary modes, fixed divisors
	// ------------------------------------------------------------
	localparam logic [2:0] SRC_FAST_RC = 3'h0;
	localparam logic [2:0] SRC_RC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRIMARY = 3'h2;
	localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
	localparam logic [2:0] SRC_SECONDARY = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
	localparam logic [2:0] SRC_RC_DIV16 = 3'h6;
	localparam logic [2:0] SRC_RC_DIVN = 3'h7;
	localparam logic [1:0] PRI_HIGH_SPEED_CRYSTAL = 2'h2;
	localparam logic [1:0] PRI_CRYSTAL = 2'h1;
	localparam logic [1:0] PRI_EXTERNAL_CLOCK = 2'h0;
	localparam logic [8:0] DIV_INSTR = 9'h002;
	localparam logic [8:0] DIV_RC16 = 9'h010;
	localparam logic [8:0] DIV_BASE = 9'h002;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic awvalid;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_ADDR_W-1:0] araddr;
		logic rready;
	} cksp_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cksp_axi_rsp_s;

	typedef struct packed {
		logic [2:0] initial_source_select;
		logic [1:0] primary_osc_mode;
	} cksp_cfg_s;

	// one-cycle ticks, one per oscillator edge
	typedef struct packed {
		logic fast_rc_osc;
		logic high_speed_crystal;
		logic crystal_mode;
		logic external_clock_input;
		logic secondary_osc;
		logic low_power_rc_osc;
	} cksp_osc_ticks_s;

	typedef struct packed {
		logic [8:0] cnt;
		logic tick;
	} cksp_div_state_s;

	// ------------------------------------------------------------
	// decoding used by the clock select module
	// ------------------------------------------------------------
	function automatic logic cksp_is_pll(input logic [2:0] src);
		return (src == SRC_RC_PLL) || (src == SRC_PRIMARY_PLL);
	endfunction

	function automatic logic [8:0] cksp_plus_base(input logic [8:0] f);
		return 9'(f + DIV_BASE);
	endfunction

endpackage

// ---- logic/cksp_tick_div.sv ----
`timescale 1ns/1ps
`default_nettype none
// divides a tick stream by a runtime divisor; divisor 0 acts as 1
module cksp_tick_div (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// tick stream
	input wire logic tick_in,
	input wire logic [8:0] divisor,
	output logic tick_out
);
	import cksp_pkg::*;

	cksp_div_state_s q, d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (tick_in) begin
			if (9'(q.cnt + 9'h001) >= divisor) begin
				d.cnt = 9'h000;
				d.tick = 1'b1;
			end else begin
				d.cnt = 9'(q.cnt + 9'h001);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_out = q.tick;

endmodule // cksp_tick_div
`default_nettype wire

// ---- logic/cksp_src_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
// routes the oscillator ticks by source code and primary mode
module cksp_src_mux (
	// selection
	input wire logic [2:0] source,
	input wire logic [1:0] primary_osc_mode,
	// ticks in
	input wire cksp_pkg::cksp_osc_ticks_s ticks,
	input wire logic rc_div16_tick,
	input wire logic rc_divn_tick,
	// ticks out
	output logic pll_in_tick,
	output logic direct_tick
);
	import cksp_pkg::*;

	logic primary_tick;

	always_comb begin
		unique case (primary_osc_mode)
			PRI_HIGH_SPEED_CRYSTAL: primary_tick = ticks.high_speed_crystal;
			PRI_CRYSTAL: primary_tick = ticks.crystal_mode;
			PRI_EXTERNAL_CLOCK: primary_tick = ticks.external_clock_input;
			default: primary_tick = 1'b0;
		endcase
	end

	always_comb begin
		pll_in_tick = 1'b0;
		direct_tick = 1'b0;
		unique case (source)
			SRC_FAST_RC: direct_tick = ticks.fast_rc_osc;
			SRC_RC_PLL: pll_in_tick = ticks.fast_rc_osc;
			SRC_PRIMARY: direct_tick = primary_tick;
			SRC_PRIMARY_PLL: pll_in_tick = primary_tick;
			SRC_SECONDARY: direct_tick = ticks.secondary_osc;
			SRC_LOW_POWER_RC: direct_tick = ticks.low_power_rc_osc;
			SRC_RC_DIV16: direct_tick = rc_div16_tick;
			SRC_RC_DIVN: direct_tick = rc_divn_tick;
		endcase
	end

endmodule // cksp_src_mux
`default_nettype wire

// ---- logic/cksp_clock_select.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - initial source comes from 3-bit source and 2-bit primary mode configuration
// - erased part starts in fast RC divide-by-N mode, code 111
// - source code maps to RC, RC+PLL, primary, primary+PLL, secondary, LOW_POWER_RC_OSC, div16, divN
// - primary mode 10 high-speed crystal, 01 crystal, 00 external clock
// - instruction clock is oscillator or PLL output divided by two
// - instruction clock up to 40 MHz is supported
// - only primary or fast RC feed the PLL, and only in PLL modes
// - PLL input divided by prescale N1 of 2 to 33 from 5-bit field
// - 9-bit feedback field sets VCO multiplication factor M
// - VCO output divided by postscale N2 of 2, 4 or 8
// - PLL output equals input times M over N1 times N2
// - prescale field zero gives division by two
// - feedback field 0x1E gives multiplication by 32
// - postscale field zero gives division by two
// - divide-by-N mode divides fast RC by 2 to 256 via 3-bit field
module cksp_clock_select (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// nonvolatile configuration
	input wire cksp_pkg::cksp_cfg_s cfg,
	// oscillators and analog PLL
	input wire cksp_pkg::cksp_osc_ticks_s osc_ticks,
	input wire logic pll_vco_tick,
	input wire logic pll_locked,
	input wire logic clock_fail_event,
	// register bus
	input wire cksp_pkg::cksp_axi_req_s axi_req,
	output cksp_pkg::cksp_axi_rsp_s axi_rsp,
	// clock outputs
	output logic osc_tick,
	output logic instruction_tick,
	output logic pll_ref_tick,
	output logic [8:0] pll_mult,
	output logic pll_enable,
	output logic secondary_osc_enable,
	output logic [2:0] active_source
);
	import cksp_pkg::*;

	typedef struct packed {
		logic init_done;
		logic [2:0] current_source;
		logic [2:0] new_source;
		logic [1:0] primary_osc_mode;
		logic switch_lock_bit;
		logic pll_lock;
		logic clock_fail_flag;
		logic secondary_osc_enable;
		logic switch_request;
		logic [4:0] pll_input_prescale;
		logic [1:0] pll_output_postscale;
		logic [2:0] rc_output_divider;
		logic [8:0] pll_feedback_divisor;
		logic [8:0] pll_mult;
		logic pll_enable;
		logic osc_tick;
		logic aw_got;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic w_got;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		cksp_axi_rsp_s rsp;
	} cksp_top_state_s;

	cksp_top_state_s q, d;

	// state after reset; the source matches an erased configuration
	localparam cksp_top_state_s RST_STATE = '{
		current_source: RST_SOURCE,
		new_source: RST_SOURCE,
		primary_osc_mode: RST_PRI_MODE,
		pll_input_prescale: RST_PRESCALE,
		pll_output_postscale: RST_POSTSCALE,
		rc_output_divider: RST_RC_DIV,
		pll_feedback_divisor: RST_FB_DIV,
		pll_mult: 9'(RST_FB_DIV + DIV_BASE),
		default: '0
	};

	// ------------------------------------------------------------
	// divisor arithmetic, write strobe merge and address decode
	// ------------------------------------------------------------
	function automatic logic [8:0] prescale_n1(input logic [4:0] f);
		return cksp_plus_base({4'h0, f});
	endfunction

	function automatic logic [8:0] feedback_m(input logic [8:0] f);
		return cksp_plus_base(f);
	endfunction

	function automatic logic [8:0] postscale_n2(input logic [1:0] f);
		unique case (f)
			2'h0: return 9'h002;
			2'h1: return 9'h004;
			default: return 9'h008;
		endcase
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
			input logic [1:0] strb);
		logic [15:0] m;
		m = {{8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction

	function automatic logic addr_is(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] off);
		return {a[7:2], 2'b00} == off;
	endfunction

	// ------------------------------------------------------------
	// register images
	// ------------------------------------------------------------
	logic [15:0] osc_ctrl_img;
	logic [15:0] clk_div_img;
	logic [15:0] fb_div_img;

	always_comb begin
		osc_ctrl_img = 16'h0000;
		osc_ctrl_img[OC_CUR_LSB +: 3] = q.current_source;
		osc_ctrl_img[OC_NEW_LSB +: 3] = q.new_source;
		osc_ctrl_img[OC_SWLOCK_BIT] = q.switch_lock_bit;
		osc_ctrl_img[OC_PLLLOCK_BIT] = q.pll_lock;
		osc_ctrl_img[OC_FAIL_BIT] = q.clock_fail_flag;
		osc_ctrl_img[OC_SECEN_BIT] = q.secondary_osc_enable;
		osc_ctrl_img[OC_SWREQ_BIT] = q.switch_request;
		clk_div_img = 16'h0000;
		clk_div_img[CD_RCDIV_LSB +: 3] = q.rc_output_divider;
		clk_div_img[CD_POST_LSB +: 2] = q.pll_output_postscale;
		clk_div_img[CD_PRE_LSB +: 5] = q.pll_input_prescale;
		fb_div_img = {7'h00, q.pll_feedback_divisor};
	end

	// ------------------------------------------------------------
	// divider chain
	// ------------------------------------------------------------
	logic rc_div16_tick;
	logic rc_divn_tick;
	logic pll_in_tick;
	logic direct_tick;
	logic pll_ref;
	logic pll_post_tick;
	logic instr_tick;

	cksp_tick_div u_rc_div16 (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick_in(osc_ticks.fast_rc_osc),
		.divisor(DIV_RC16),
		.tick_out(rc_div16_tick)
	);

	cksp_tick_div u_rc_divn (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick_in(osc_ticks.fast_rc_osc),
		.divisor(9'(DIV_BASE << q.rc_output_divider)),
		.tick_out(rc_divn_tick)
	);

	cksp_src_mux u_mux (
		.source(q.current_source),
		.primary_osc_mode(q.primary_osc_mode),
		.ticks(osc_ticks),
		.rc_div16_tick(rc_div16_tick),
		.rc_divn_tick(rc_divn_tick),
		.pll_in_tick(pll_in_tick),
		.direct_tick(direct_tick)
	);

	cksp_tick_div u_prescale (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick_in(pll_in_tick),
		.divisor(prescale_n1(q.pll_input_prescale)),
		.tick_out(pll_ref)
	);

	// the VCO multiplies the reference by pll_mult; its edges come back here
	cksp_tick_div u_postscale (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick_in(pll_vco_tick & q.pll_enable),
		.divisor(postscale_n2(q.pll_output_postscale)),
		.tick_out(pll_post_tick)
	);

	// instruction rate is half the oscillator rate, 40 MHz at an 80 MHz source
	cksp_tick_div u_instr (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick_in(q.osc_tick),
		.divisor(DIV_INSTR),
		.tick_out(instr_tick)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic [15:0] wr_img;

	always_comb begin
		d = q;
		wr_img = 16'h0000;

		// configuration capture in the first cycle after reset
		if (!q.init_done) begin
			d.init_done = 1'b1;
			d.current_source = cfg.initial_source_select;
			d.new_source = cfg.initial_source_select;
			d.primary_osc_mode = cfg.primary_osc_mode;
		end

		// a pending switch takes effect one cycle after the request
		if (q.switch_request) begin
			d.current_source = q.new_source;
			d.switch_request = 1'b0;
		end

		d.pll_lock = pll_locked;
		d.pll_mult = feedback_m(q.pll_feedback_divisor);
		d.osc_tick = q.pll_enable ? pll_post_tick : direct_tick;

		// write address and write data are taken in either order
		if (axi_req.awvalid && q.rsp.awready) begin
			d.aw_got = 1'b1;
			d.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && q.rsp.wready) begin
			d.w_got = 1'b1;
			d.wdata = axi_req.wdata[15:0];
			d.wstrb = axi_req.wstrb[1:0];
		end

		// both halves held: update the register and raise the response
		if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = RESP_OKAY;
			if (addr_is(q.awaddr, OFF_OSC_CTRL)) begin
				wr_img = merge16(osc_ctrl_img, q.wdata, q.wstrb);
				d.new_source = wr_img[OC_NEW_LSB +: 3];
				d.switch_lock_bit = wr_img[OC_SWLOCK_BIT];
				d.secondary_osc_enable = wr_img[OC_SECEN_BIT];
				d.switch_request = wr_img[OC_SWREQ_BIT];
				// the fail flag can only be cleared from software
				if (!wr_img[OC_FAIL_BIT]) begin
					d.clock_fail_flag = 1'b0;
				end
			end else if (addr_is(q.awaddr, OFF_CLK_DIV)) begin
				wr_img = merge16(clk_div_img, q.wdata, q.wstrb);
				d.rc_output_divider = wr_img[CD_RCDIV_LSB +: 3];
				d.pll_output_postscale = wr_img[CD_POST_LSB +: 2];
				d.pll_input_prescale = wr_img[CD_PRE_LSB +: 5];
			end else if (addr_is(q.awaddr, OFF_FB_DIV)) begin
				wr_img = merge16(fb_div_img, q.wdata, q.wstrb);
				d.pll_feedback_divisor = wr_img[8:0];
			end else begin
				d.rsp.bresp = RESP_SLVERR;
			end
		end
		if (q.rsp.bvalid && axi_req.bready) begin
			d.rsp.bvalid = 1'b0;
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
		end

		// a failure seen in the same cycle as a clear leaves the flag set
		if (clock_fail_event) begin
			d.clock_fail_flag = 1'b1;
		end

		// read channel: one read at a time, data held until taken
		if (axi_req.arvalid && q.rsp.arready) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rresp = RESP_OKAY;
			if (addr_is(axi_req.araddr, OFF_OSC_CTRL)) begin
				d.rsp.rdata = {16'h0000, osc_ctrl_img};
			end else if (addr_is(axi_req.araddr, OFF_CLK_DIV)) begin
				d.rsp.rdata = {16'h0000, clk_div_img};
			end else if (addr_is(axi_req.araddr, OFF_FB_DIV)) begin
				d.rsp.rdata = {16'h0000, fb_div_img};
			end else begin
				d.rsp.rdata = 32'h0000_0000;
				d.rsp.rresp = RESP_SLVERR;
			end
		end
		if (q.rsp.rvalid && axi_req.rready) begin
			d.rsp.rvalid = 1'b0;
		end

		// ready levels follow the held state, so each is a register
		d.rsp.awready = !d.aw_got;
		d.rsp.wready = !d.w_got;
		d.rsp.arready = !d.rsp.rvalid;
		d.pll_enable = cksp_is_pll(d.current_source);
	end

	// ------------------------------------------------------------
	// state register and outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	assign axi_rsp = q.rsp;
	assign osc_tick = q.osc_tick;
	assign instruction_tick = instr_tick;
	assign pll_ref_tick = pll_ref;
	assign pll_mult = q.pll_mult;
	assign pll_enable = q.pll_enable;
	assign secondary_osc_enable = q.secondary_osc_enable;
	assign active_source = q.current_source;

endmodule // cksp_clock_select
`default_nettype wire

// ---- verif/cksp_clock_select_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module cksp_clock_select_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// inputs
	input wire cksp_pkg::cksp_cfg_s cfg,
	input wire cksp_pkg::cksp_osc_ticks_s osc_ticks,
	input wire logic pll_vco_tick,
	input wire cksp_pkg::cksp_axi_req_s axi_req,
	// outputs
	input wire cksp_pkg::cksp_axi_rsp_s axi_rsp,
	input wire logic osc_tick,
	input wire logic instruction_tick,
	input wire logic pll_ref_tick,
	input wire logic [8:0] pll_mult,
	input wire logic pll_enable,
	input wire logic [2:0] active_source
);
	import cksp_pkg::*;
	// ----------------
	// helper counters
	// ----------------
	logic [1:0] since_q;
	logic [4:0] quiet_q;
	logic pll_src;
	assign pll_src = (active_source == SRC_RC_PLL) || (active_source == SRC_PRIMARY_PLL);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			since_q <= 2'h0;
			quiet_q <= 5'h00;
		end else begin
			if (instruction_tick)
				since_q <= {1'b0, osc_tick};
			else if (osc_tick && since_q != 2'h3)
				since_q <= since_q + 2'h1;
			if ((|osc_ticks) || pll_vco_tick)
				quiet_q <= 5'h00;
			else if (quiet_q != 5'h1f)
				quiet_q <= quiet_q + 5'h01;
		end
	end
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_ref_pll_only: assert property (pll_ref_tick |-> pll_src)
		else $error("pll reference tick in a direct mode");
	a_pll_off_direct: assert property (!pll_src |-> !pll_enable)
		else $error("pll enabled in a direct mode");
	a_instr_half_rate: assert property (since_q != 2'h3)
		else $error("instruction tick missing");
	a_outputs_quiet: assert property (quiet_q == 5'h1f |-> !osc_tick && !pll_ref_tick)
		else $error("clock output without oscillator input");
	a_start_source: assert property ($fell(rst) |=> active_source == cfg.initial_source_select)
		else $error("wrong source after reset");
	a_mult_floor: assert property (pll_mult >= 9'h002)
		else $error("multiplier below base");
	a_write_resp_once: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
		else $error("write response repeated");
	a_read_resp_once: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
		else $error("read response repeated");
endmodule // cksp_clock_select_checker

bind cksp_clock_select cksp_clock_select_checker i_chk (.clk_sys(clk_sys), .rst(rst),
	.cfg(cfg), .osc_ticks(osc_ticks), .pll_vco_tick(pll_vco_tick), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .osc_tick(osc_tick), .instruction_tick(instruction_tick),
	.pll_ref_tick(pll_ref_tick), .pll_mult(pll_mult), .pll_enable(pll_enable),
	.active_source(active_source));
`default_nettype wire

// ---- verif/system_clock_select_pll_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_pll_tb;
	import cksp_pkg::*;
	typedef struct {int s, m, d, k, nt, nv, er, eo;} cksp_row_s;
	cksp_row_s rows [14] = '{'{0, 0, 0, 32, 8, 8, 0, 8}, '{2, 2, 0, 16, 8, 8, 0, 8},
		'{2, 1, 0, 8, 8, 8, 0, 8}, '{2, 0, 0, 4, 8, 8, 0, 8}, '{4, 0, 0, 2, 8, 8, 0, 8},
		'{5, 0, 0, 1, 8, 8, 0, 8}, '{6, 0, 0, 32, 32, 8, 0, 2}, '{7, 0, 0, 32, 8, 8, 0, 4},
		'{7, 0, 'h700, 32, 512, 8, 0, 2}, '{1, 0, 'hdf, 32, 66, 16, 2, 2},
		'{1, 0, 'h41, 32, 6, 8, 2, 2}, '{3, 1, 0, 8, 8, 8, 4, 4}, '{3, 2, 0, 16, 4, 8, 2, 4},
		'{3, 0, 0, 4, 4, 8, 2, 4}};
	logic clk_sys, rst, vco, clr, pll_enable, osc_tick, ins_tick, ref_tick, sec_en;
	cksp_cfg_s cfg;
	cksp_osc_ticks_s tk;
	cksp_axi_req_s rq;
	cksp_axi_rsp_s rs;
	logic [8:0] pll_mult;
	logic [2:0] act;
	int bad_count, cmp_count, cyc, n_osc, n_ins, n_ref;

	cksp_clock_select i_dut (.clk_sys(clk_sys), .rst(rst), .cfg(cfg), .osc_ticks(tk),
		.pll_vco_tick(vco), .pll_locked(1'b1), .clock_fail_event(1'b0), .axi_req(rq),
		.axi_rsp(rs), .osc_tick(osc_tick), .instruction_tick(ins_tick),
		.pll_ref_tick(ref_tick), .pll_mult(pll_mult), .pll_enable(pll_enable),
		.secondary_osc_enable(sec_en), .active_source(act));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (clr) begin
			n_osc = 0;
			n_ins = 0;
			n_ref = 0;
		end else begin
			n_osc += osc_tick;
			n_ins += ins_tick;
			n_ref += ref_tick;
		end
		if (cyc == 10000) begin
			bad_count++;
			stop_test;
		end
	end
	// ----------------
	// shared tasks
	// ----------------
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task stop_test;
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task do_reset(input int s, input int m);
		cfg <= '{3'(s), 2'(m)};
		rst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		rq.awaddr <= a;
		rq.wdata <= d;
		rq.wstrb <= 4'hf;
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (rs.awready) rq.awvalid <= 1'b0;
			if (rs.wready) rq.wvalid <= 1'b0;
		end while (!rs.bvalid);
		rq.bready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		rq.araddr <= a;
		rq.arvalid <= 1'b1;
		rq.rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (rs.arready) rq.arvalid <= 1'b0;
		end while (!rs.rvalid);
		d = rs.rdata;
		r = rs.rresp;
		rq.rready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task pulse(input logic [5:0] m, input logic v, input int n);
		repeat (n) begin
			tk <= cksp_osc_ticks_s'(m);
			vco <= v;
			@(posedge clk_sys);
			tk <= '0;
			vco <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	// ----------------
	// scenarios
	// ----------------
	task t_sources;
		logic [31:0] d;
		logic [1:0] r;
		foreach (rows[i]) begin
			do_reset(rows[i].s, rows[i].m);
			wr(OFF_CLK_DIV, 32'(rows[i].d));
			clr <= 1'b1;
			@(posedge clk_sys);
			clr <= 1'b0;
			pulse(6'(rows[i].k), 1'b0, rows[i].nt);
			pulse(~6'(rows[i].k), 1'b0, 8);
			pulse(6'h00, 1'b1, rows[i].nv);
			repeat (40) @(posedge clk_sys);
			chk("osc ticks", n_osc, rows[i].eo);
			chk("instr ticks", n_ins, rows[i].eo / 2);
			chk("ref ticks", n_ref, rows[i].er);
			chk("pll enable", pll_enable, rows[i].er != 0);
			chk("active source", act, rows[i].s);
			rd(OFF_OSC_CTRL, d, r);
			chk("current source", d[14:12], rows[i].s);
			chk("new source", d[10:8], rows[i].s);
		end
	endtask
	task t_regs;
		logic [31:0] d;
		logic [1:0] r;
		do_reset(7, 0);
		rd(OFF_FB_DIV, d, r);
		chk("erased source", act, SRC_RC_DIVN);
		chk("fb reset", d[8:0], RST_FB_DIV);
		wr(OFF_FB_DIV, 32'h0000_001e);
		rd(OFF_FB_DIV, d, r);
		chk("fb field", d[8:0], 9'h01e);
		chk("multiplier", pll_mult, 9'h020);
		wr(OFF_OSC_CTRL, 32'h0000_0002);
		rd(OFF_OSC_CTRL, d, r);
		chk("current source ro", d[14:12], 3'h7);
		chk("new source wr", d[10:8], 3'h0);
		chk("secondary enable", sec_en, 1'b1);
		wr(OFF_OSC_CTRL, 32'h0000_0001);
		rd(OFF_OSC_CTRL, d, r);
		chk("switched source", d[14:12], 3'h0);
		chk("switch request", d[0], 1'b0);
		chk("switched output", act, 3'h0);
		rd(8'h40, d, r);
		chk("unmapped resp", r, RESP_SLVERR);
	endtask

	initial begin
		rst = 1'b1;
		cfg = '0;
		tk = '0;
		vco = 1'b0;
		rq = '0;
		clr = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		cyc = 0;
		t_sources;
		t_regs;
		stop_test;
	end
endmodule // system_clock_select_pll_tb
`default_nettype wire
